// >>> adcseq_assertions.sv
// Checker: bus and sequencer properties seen at the ports
`timescale 1ns/10ps
// ==========
// Properties
module adcseq_assertions (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic convDone,
	input wire adcseq_pkg::adcseq_analog_type analogCtl,
	input wire adcseq_pkg::adcseq_mux_type muxSel,
	input wire logic irq
);
	import adcseq_pkg::*;
	logic [7:0] wAddr_ff;
	logic [31:0] wData_ff;
	logic [3:0] wStrb_ff;
	// Nothing new is taken before the mux check reads these
	always_ff @(posedge clk)
	begin
		if (s_axi_awvalid && s_axi_awready)
			wAddr_ff <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready)
		begin
			wData_ff <= s_axi_wdata;
			wStrb_ff <= s_axi_wstrb;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	start_pulse_a: assert property (analogCtl.convStart |=> !analogCtl.convStart)
		else $error("start pulse too long");
	sample_conv_a: assert property ($rose(analogCtl.convStart) |->
		$past(analogCtl.sampling) || $past(analogCtl.sampling, 2)) else $error("start without sample");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	data_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	// Byte lanes beyond the last register word are unmapped
	unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr[7:2] > 6'h03 |=>
		s_axi_rresp == ADCSEQ_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
	// Full-word writes only; partial lanes keep old bits
	mux_follow_a: assert property ($rose(s_axi_bvalid) && wStrb_ff == 4'hf
		&& wAddr_ff == ADCSEQ_INPUT_SELECT_OFFS |=>
		muxSel == {wData_ff[31], wData_ff[28:24], wData_ff[23], wData_ff[20:16]})
		else $error("mux select wrong");
	irq_cause_a: assert property ($rose(irq) |-> convDone)
		else $error("interrupt without result");
	cover property (analogCtl.convStart);
	cover property ($rose(irq));
	cover property (s_axi_rvalid && s_axi_rresp == ADCSEQ_RESP_SLVERR);
endmodule : adcseq_assertions

bind adcseq_sequencer adcseq_assertions i_adcseq_assertions (.clk, .rst, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .convDone, .analogCtl,
	.muxSel, .irq);

// >>> adcseq_core_model.sv
// Model of the sample-and-hold and converter core
`timescale 1ns/10ps
// ==========
// Converter core
module adcseq_core_model (
	input wire logic clk,
	input wire logic rst,
	input wire adcseq_pkg::adcseq_analog_type analogCtl,
	input wire logic [7:0] latency,
	output logic convDone
);
	import adcseq_pkg::*;
	logic [7:0] count_ff;
	// Result level holds until the next start, like a real core
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			count_ff <= 8'h0;
			convDone <= 1'b0;
		end
		else if (analogCtl.convStart)
		begin
			count_ff <= latency;
			convDone <= 1'b0;
		end
		else if (count_ff != 8'h0)
		begin
			count_ff <= count_ff - 8'h1;
			convDone <= (count_ff == 8'h1);
		end
	end
endmodule : adcseq_core_model

// >>> adcseq_pkg.sv
// Package: register map, field layout and types of the converter sequencer
package adcseq_pkg;

	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] ADCSEQ_CONTROL_ONE_OFFS = 8'h00;
	localparam logic [7:0] ADCSEQ_INPUT_SELECT_OFFS = 8'h04;
	localparam logic [7:0] ADCSEQ_IRQ_STATUS_OFFS = 8'h08;
	localparam logic [7:0] ADCSEQ_IRQ_MASK_OFFS = 8'h0c;

	// ==========================================
	// Control register fields
	localparam int ADCSEQ_DONE_BIT = 0;
	localparam int ADCSEQ_SAMPLE_ENABLE_FLAG_BIT = 1;
	localparam int ADCSEQ_AUTO_BIT = 2;
	localparam int ADCSEQ_STOP_BIT = 4;
	localparam int ADCSEQ_TRIG_LSB = 5;
	localparam logic [2:0] ADCSEQ_TRIG_MANUAL = 3'h0;

	// ==========================================
	// Input select fields
	localparam int ADCSEQ_NEGB_BIT = 31;
	localparam int ADCSEQ_POSB_LSB = 24;
	localparam int ADCSEQ_NEGA_BIT = 23;
	localparam int ADCSEQ_POSA_LSB = 16;
	localparam logic [4:0] ADCSEQ_POS_LAST_ANALOG = 5'h1b;
	localparam logic [4:0] ADCSEQ_POS_INT_REF = 5'h1c;
	localparam logic [4:0] ADCSEQ_POS_TEMP = 5'h1d;
	localparam logic [4:0] ADCSEQ_POS_OPEN = 5'h1e;

	// ==========================================
	// Reset values and timing
	localparam logic [31:0] ADCSEQ_CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] ADCSEQ_SELECT_RESET = 32'h0000_0000;
	localparam logic [3:0] ADCSEQ_SAMPLE_CYCLES = 4'h8;
	localparam logic [1:0] ADCSEQ_RESP_OKAY = 2'h0;
	localparam logic [1:0] ADCSEQ_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic negSelB;
		logic [4:0] posSelB;
		logic negSelA;
		logic [4:0] posSelA;
	} adcseq_mux_type;

	typedef struct packed {
		logic sampling;
		logic convStart;
	} adcseq_analog_type;

endpackage : adcseq_pkg

// >>> adcseq_sequencer.sv
// Sample and conversion sequencer with AXI4-Lite registers
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
// ==========================================
// How it works
// - Stop bit set: first conversion interrupt clears auto-start, halting further runs.
// - Stop bit clear: conversions repeat, each overwriting the previous result.
// - Auto-start set: sampling restarts right after conversion completes, flag set.
// - Auto-start clear: sampling starts only on a software write of one.
// - Sample flag reads one while sampling, zero while holding.
// - Manual trigger: software writing zero to sample flag starts conversion.
// - Non-manual trigger: hardware clears sample flag, starting conversion.
// - Done flag set when conversion finishes; zero otherwise.
// - Software clears done by writing zero; conversion in progress unaffected.
// - Done flag cleared by hardware when a new conversion begins.
// - Input select bit 31 picks sample B negative input.
// - Bits 28..24 pick sample B positive input code.
// - Input select bit 23 picks sample A negative input.
// - Bits 20..16 pick sample A positive input, same codes.
module adcseq_sequencer (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic convDone,
	output adcseq_pkg::adcseq_analog_type analogCtl,
	output adcseq_pkg::adcseq_mux_type muxSel,
	output logic irq
);
	import adcseq_pkg::*;

	typedef enum {IDLE, SAMPLE, CONVERT} adcseq_state_type;

	adcseq_state_type state_ff;
	logic [3:0] sampleCnt_ff, wStrb_ff;
	logic [2:0] trigSrc_ff;
	logic [7:0] awAddr_ff;
	logic [31:0] inputSel_ff, wData_ff, nxt_rdata;
	logic [1:0] nxt_rresp;
	logic autoStart_ff, stopOnIrq_ff, sampleFlag_ff, doneFlag_ff, irqStatus_ff, irqMask_ff;
	logic convDoneMeta_ff, convDoneSync_ff, convDonePrev_ff, awHeld_ff, wHeld_ff;
	logic nxt_bvalid, wrFire, wrCtl, wrSel, wrStat, wrMask, convEvent;
	logic swStartSample, swEndSample, hwEndSample, convBegin;

	// Byte-lane merge, used for the input select register only
	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction : mergeBytes

	// ==========================================
	// Bus write channel
	// Address and data captured independently, either order
	assign wrFire = awHeld_ff && wHeld_ff && !s_axi_bvalid;
	assign wrCtl = wrFire && awAddr_ff == ADCSEQ_CONTROL_ONE_OFFS;
	assign wrSel = wrFire && awAddr_ff == ADCSEQ_INPUT_SELECT_OFFS;
	assign wrStat = wrFire && awAddr_ff == ADCSEQ_IRQ_STATUS_OFFS;
	assign wrMask = wrFire && awAddr_ff == ADCSEQ_IRQ_MASK_OFFS;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			awHeld_ff <= 1'b0;
			awAddr_ff <= 8'h00;
			s_axi_awready <= 1'b0;
		end
		else if (wrFire)
		begin
			awHeld_ff <= 1'b0;
			s_axi_awready <= 1'b0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			awHeld_ff <= 1'b1;
			awAddr_ff <= {s_axi_awaddr[7:2], 2'b00};
			s_axi_awready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !awHeld_ff;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wHeld_ff <= 1'b0;
			wData_ff <= 32'h0000_0000;
			wStrb_ff <= 4'h0;
			s_axi_wready <= 1'b0;
		end
		else if (wrFire)
		begin
			wHeld_ff <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			wHeld_ff <= 1'b1;
			wData_ff <= s_axi_wdata;
			wStrb_ff <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_wready <= !wHeld_ff;
		end
	end

	// Response stands until taken; a new one only once the old is gone
	assign nxt_bvalid = wrFire || (s_axi_bvalid && !s_axi_bready);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ADCSEQ_RESP_OKAY;
		end
		else
		begin
			s_axi_bvalid <= nxt_bvalid;
			if (wrFire)
			begin
				s_axi_bresp <= (wrCtl || wrSel || wrStat || wrMask) ? ADCSEQ_RESP_OKAY
					: ADCSEQ_RESP_SLVERR;
			end
		end
	end

	// ==========================================
	// Bus read channel
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		nxt_rresp = ADCSEQ_RESP_OKAY;
		unique case ({s_axi_araddr[7:2], 2'b00})
			ADCSEQ_CONTROL_ONE_OFFS:
			begin
				nxt_rdata[ADCSEQ_SAMPLE_ENABLE_FLAG_BIT] = sampleFlag_ff;
				nxt_rdata[ADCSEQ_DONE_BIT] = doneFlag_ff;
				nxt_rdata[ADCSEQ_AUTO_BIT] = autoStart_ff;
				nxt_rdata[ADCSEQ_STOP_BIT] = stopOnIrq_ff;
				nxt_rdata[ADCSEQ_TRIG_LSB +: 3] = trigSrc_ff;
			end
			ADCSEQ_INPUT_SELECT_OFFS: nxt_rdata = inputSel_ff;
			ADCSEQ_IRQ_STATUS_OFFS: nxt_rdata[0] = irqStatus_ff;
			ADCSEQ_IRQ_MASK_OFFS: nxt_rdata[0] = irqMask_ff;
			default: nxt_rresp = ADCSEQ_RESP_SLVERR;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= ADCSEQ_RESP_OKAY;
		end
		else if (s_axi_rvalid)
		begin
			s_axi_arready <= 1'b0;
			if (s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
			end
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= nxt_rdata;
			s_axi_rresp <= nxt_rresp;
		end
		else
		begin
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================
	// Converter done input, from the analog side
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			convDoneMeta_ff <= 1'b0;
			convDoneSync_ff <= 1'b0;
			convDonePrev_ff <= 1'b0;
		end
		else
		begin
			convDoneMeta_ff <= convDone;
			convDoneSync_ff <= convDoneMeta_ff;
			convDonePrev_ff <= convDoneSync_ff;
		end
	end

	assign convEvent = state_ff == CONVERT && convDoneSync_ff && !convDonePrev_ff;

	// ==========================================
	// Sequencer
	// only a written one starts sampling when auto-start is off
	assign swStartSample = wrCtl && wStrb_ff[0] && wData_ff[ADCSEQ_SAMPLE_ENABLE_FLAG_BIT] && !sampleFlag_ff;
	// manual trigger, written zero ends sampling
	assign swEndSample = wrCtl && wStrb_ff[0] && !wData_ff[ADCSEQ_SAMPLE_ENABLE_FLAG_BIT]
		&& trigSrc_ff == ADCSEQ_TRIG_MANUAL && state_ff == SAMPLE;
	// any other trigger ends sampling after a fixed sample time
	assign hwEndSample = state_ff == SAMPLE && trigSrc_ff != ADCSEQ_TRIG_MANUAL
		&& sampleCnt_ff == 4'h0;
	assign convBegin = swEndSample || hwEndSample;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_ff <= IDLE;
			sampleFlag_ff <= 1'b0;
			sampleCnt_ff <= 4'h0;
		end
		else
		begin
			unique case (state_ff)
				IDLE:
				begin
					if (swStartSample || autoStart_ff)
					begin
						state_ff <= SAMPLE;
						sampleFlag_ff <= 1'b1;
						sampleCnt_ff <= ADCSEQ_SAMPLE_CYCLES;
					end
				end
				SAMPLE:
				begin
					if (convBegin)
					begin
						state_ff <= CONVERT;
						sampleFlag_ff <= 1'b0;
					end
					else if (sampleCnt_ff != 4'h0)
						sampleCnt_ff <= sampleCnt_ff - 4'h1;
				end
				CONVERT:
				begin
					if (convEvent && autoStart_ff && !stopOnIrq_ff)
					begin
						state_ff <= SAMPLE;
						sampleFlag_ff <= 1'b1;
						sampleCnt_ff <= ADCSEQ_SAMPLE_CYCLES;
					end
					// stop set or auto-start off: back to idle, no further run
					else if (convEvent)
						state_ff <= IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// Control register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			autoStart_ff <= ADCSEQ_CONTROL_RESET[ADCSEQ_AUTO_BIT];
			stopOnIrq_ff <= ADCSEQ_CONTROL_RESET[ADCSEQ_STOP_BIT];
			trigSrc_ff <= ADCSEQ_CONTROL_RESET[ADCSEQ_TRIG_LSB +: 3];
		end
		else
		begin
			if (wrCtl && wStrb_ff[0])
			begin
				autoStart_ff <= wData_ff[ADCSEQ_AUTO_BIT];
				stopOnIrq_ff <= wData_ff[ADCSEQ_STOP_BIT];
				trigSrc_ff <= wData_ff[ADCSEQ_TRIG_LSB +: 3];
			end
			// first interrupt clears auto-start, hardware wins over write
			if (convEvent && stopOnIrq_ff)
			begin
				autoStart_ff <= 1'b0;
			end
		end
	end

	// Done flag: set wins over a simultaneous software clear
	always_ff @(posedge clk)
	begin
		if (rst)
			doneFlag_ff <= ADCSEQ_CONTROL_RESET[ADCSEQ_DONE_BIT];
		else if (convEvent)
			doneFlag_ff <= 1'b1;
		// cleared as a new conversion begins
		else if (convBegin)
			doneFlag_ff <= 1'b0;
		// written zero clears, a written one is ignored
		else if (wrCtl && wStrb_ff[0] && !wData_ff[ADCSEQ_DONE_BIT])
			doneFlag_ff <= 1'b0;
	end

	// ==========================================
	// Input select register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			inputSel_ff <= ADCSEQ_SELECT_RESET;
		end
		else if (wrSel)
		begin
			// keep only implemented bits, rest read zero
			inputSel_ff <= mergeBytes(inputSel_ff, wData_ff, wStrb_ff) & 32'h9f9f_0000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			muxSel <= '0;
			analogCtl <= '0;
		end
		else
		begin
			muxSel.negSelB <= inputSel_ff[ADCSEQ_NEGB_BIT];
			muxSel.posSelB <= inputSel_ff[ADCSEQ_POSB_LSB +: 5];
			muxSel.negSelA <= inputSel_ff[ADCSEQ_NEGA_BIT];
			// sample A positive input, same codes
			muxSel.posSelA <= inputSel_ff[ADCSEQ_POSA_LSB +: 5];
			analogCtl.sampling <= sampleFlag_ff;
			analogCtl.convStart <= convBegin;
		end
	end

	// ==========================================
	// Interrupt status and mask
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			irqStatus_ff <= 1'b0;
			irqMask_ff <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			// event is sticky; set beats write-one-clear
			if (convEvent)
				irqStatus_ff <= 1'b1;
			else if (wrStat && wStrb_ff[0] && wData_ff[0])
				irqStatus_ff <= 1'b0;
			if (wrMask && wStrb_ff[0])
			begin
				irqMask_ff <= wData_ff[0];
			end
			irq <= irqStatus_ff && irqMask_ff;
		end
	end

endmodule : adcseq_sequencer

// >>> testbench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
// ==========
// Bench
module testbench;
	import adcseq_pkg::*;
	logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, convDone, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr, lat;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	adcseq_analog_type analogCtl;
	adcseq_mux_type muxSel;
	logic [4:0] codes [5];
	int checks, nMismatch, starts, k;
	adcseq_sequencer i_adcseq_sequencer (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .convDone, .analogCtl, .muxSel, .irq);
	adcseq_core_model i_adcseq_core_model (.clk, .rst, .analogCtl, .latency(lat), .convDone);
	always #2.5 clk = ~clk;
	always @(posedge clk)
		if (analogCtl.convStart === 1'b1)
			starts <= starts + 1;
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, nMismatch);
		if (nMismatch == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			nMismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	// A used-up wait ends the run at once
	task automatic guard(input int n, input int lim);
		if (n >= lim)
		begin
			nMismatch++;
			report_and_stop();
		end
	endtask : guard
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		s_axi_bready <= 1'b0;
		guard(n, 50);
		check(32'(s_axi_bresp), 32'(er));
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		int n;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		s_axi_rready <= 1'b0;
		guard(n, 50);
		d = s_axi_rdata;
		check(32'(s_axi_rresp), 32'(er));
	endtask : rd
	task automatic wait_done(output logic [31:0] d);
		int n;
		for (n = 0; n < 100; n++)
		begin
			rd(ADCSEQ_CONTROL_ONE_OFFS, ADCSEQ_RESP_OKAY, d);
			if (d[0] === 1'b1)
				break;
		end
		guard(n, 100);
	endtask : wait_done
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_awaddr = 8'h0;
		s_axi_araddr = 8'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		lat = 8'h14;
		codes = '{5'h00, ADCSEQ_POS_LAST_ANALOG, ADCSEQ_POS_INT_REF, ADCSEQ_POS_TEMP, ADCSEQ_POS_OPEN};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(ADCSEQ_CONTROL_ONE_OFFS, ADCSEQ_RESP_OKAY, v);
		check(v, ADCSEQ_CONTROL_RESET);
		rd(8'h10, ADCSEQ_RESP_SLVERR, v);
		check(v, 32'h0);
		wr(8'h10, 32'hffff_ffff, ADCSEQ_RESP_SLVERR);
		wr(ADCSEQ_INPUT_SELECT_OFFS, 32'hffff_ffff, ADCSEQ_RESP_OKAY);
		rd(ADCSEQ_INPUT_SELECT_OFFS, ADCSEQ_RESP_OKAY, v);
		check(v, 32'h9f9f_0000);
		foreach (codes[i])
		begin
			wr(ADCSEQ_INPUT_SELECT_OFFS, {3'h4, codes[i], 3'h0, codes[i], 16'h0}, ADCSEQ_RESP_OKAY);
			rd(ADCSEQ_INPUT_SELECT_OFFS, ADCSEQ_RESP_OKAY, v);
			check(v, {3'h4, codes[i], 3'h0, codes[i], 16'h0});
			check(32'(muxSel), {20'h0, 1'b1, codes[i], 1'b0, codes[i]});
		end
		// Manual start and end of sampling
		wr(ADCSEQ_CONTROL_ONE_OFFS, 32'h2, ADCSEQ_RESP_OKAY);
		rd(ADCSEQ_CONTROL_ONE_OFFS, ADCSEQ_RESP_OKAY, v);
		check(v, 32'h2);
		repeat (20) @(posedge clk);
		check(32'(analogCtl.sampling), 32'h1);
		check(32'(starts), 32'h0);
		wr(ADCSEQ_CONTROL_ONE_OFFS, 32'h0, ADCSEQ_RESP_OKAY);
		wait_done(v);
		check(v, 32'h1);
		check(32'(starts), 32'h1);
		check(32'(analogCtl.sampling), 32'h0);
		check(32'(irq), 32'h0);
		rd(ADCSEQ_IRQ_STATUS_OFFS, ADCSEQ_RESP_OKAY, v);
		check(v, 32'h1);
		wr(ADCSEQ_IRQ_MASK_OFFS, 32'h1, ADCSEQ_RESP_OKAY);
		repeat (3) @(posedge clk);
		check(32'(irq), 32'h1);
		wr(ADCSEQ_IRQ_STATUS_OFFS, 32'h1, ADCSEQ_RESP_OKAY);
		repeat (3) @(posedge clk);
		check(32'(irq), 32'h0);
		wr(ADCSEQ_CONTROL_ONE_OFFS, 32'h0, ADCSEQ_RESP_OKAY);
		wr(ADCSEQ_CONTROL_ONE_OFFS, 32'h1, ADCSEQ_RESP_OKAY);
		rd(ADCSEQ_CONTROL_ONE_OFFS, ADCSEQ_RESP_OKAY, v);
		check(v, 32'h0);
		// Auto start with stop at first result
		wr(ADCSEQ_CONTROL_ONE_OFFS, 32'h34, ADCSEQ_RESP_OKAY);
		wait_done(v);
		repeat (60) @(posedge clk);
		rd(ADCSEQ_CONTROL_ONE_OFFS, ADCSEQ_RESP_OKAY, v);
		check(v, 32'h31);
		check(32'(starts), 32'h2);
		wr(ADCSEQ_IRQ_STATUS_OFFS, 32'h1, ADCSEQ_RESP_OKAY);
		// Slow core, repeated runs
		lat <= 8'h3c;
		wr(ADCSEQ_CONTROL_ONE_OFFS, 32'h24, ADCSEQ_RESP_OKAY);
		for (k = 0; k < 600 && starts < 4; k++)
			@(posedge clk);
		guard(k, 600);
		rd(ADCSEQ_CONTROL_ONE_OFFS, ADCSEQ_RESP_OKAY, v);
		check(v, 32'h24);
		wait_done(v);
		check(v, 32'h27);
		report_and_stop();
	end
endmodule : testbench
